// file: core/cit_core_timing.v
// cit_core_timing: executes one issued operation at a time with the core's cycle timing
// assumes: issue and bus-pending inputs come from logic on SYS_CLK, no synchroniser
`timescale 1ns/10ps
`include "cit_defines.vh"

module cit_core_timing (
  // clock and reset
  input wire SYS_CLK,
  input wire RST_N,
  // issue port
  input wire ISSUE_VALID,
  input wire [4:0] ISSUE_OP,
  input wire [31:0] ISSUE_A,
  input wire [31:0] ISSUE_B,
  input wire [4:0] ISSUE_REG_COUNT,
  output reg ISSUE_READY,
  // system bus status
  input wire BUS_PENDING,
  // completion
  output reg DONE,
  output reg [4:0] DONE_OP,
  output reg [4:0] CYCLES,
  output reg [31:0] RESULT,
  output reg RESULT_WE,
  output reg CARRY,
  output reg BRANCH_TAKEN,
  output reg [31:0] BRANCH_TARGET,
  output reg HALT_REQ
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_BUSY = 2'h1;
  localparam ST_DRAIN = 2'h2;
  reg [1:0] st_q;
  reg [1:0] st_d;
  // one bit wider than CYCLES: 31 registers still occupy 32 cycles
  reg [5:0] cnt_q;
  reg [5:0] cnt_d;
  reg [5:0] occ;
  reg ready_d;
  reg done_d;
  reg halt_d;
  reg [4:0] op_q;
  reg [4:0] op_sel;

  // decoded values of the operation being accepted
  reg [4:0] n_cyc;
  reg [31:0] res_v;
  reg res_we_v;
  reg carry_v;
  reg taken_v;
  reg [31:0] target_v;
  reg [31:0] dec_v;
  reg [31:0] shl_v;
  reg [31:0] shr_v;
  reg [5:0] shamt;

  wire accept;
  wire [31:0] multiply_op_product;
  wire [4:0] multiply_op_latency;
  wire [3:0] byte_nz;
  wire issue_halt;

  assign accept = ISSUE_VALID & ISSUE_READY;

  cit_multiply_op_latency u_multiply_op (
    .op_a(ISSUE_A),
    .op_b(ISSUE_B),
    .product(multiply_op_product),
    .latency(multiply_op_latency)
  );

  function is_halt_op;
    input [4:0] op;
    begin
      is_halt_op = (op == `CIT_OP_BREAKPOINT_OP) || (op == `CIT_OP_DOZE_OP) ||
                   (op == `CIT_OP_WAIT_OP) || (op == `CIT_OP_STOP_OP);
    end
  endfunction

  assign issue_halt = is_halt_op(ISSUE_OP);

  // ----------------------------------------------------------------
  // per-byte zero detect for the byte test
  // ----------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_byte
      assign byte_nz[gb] = (ISSUE_A[8*gb+7:8*gb] != 8'h00);
    end
  endgenerate

  // ----------------------------------------------------------------
  // shifter shared by the shift operations
  // ----------------------------------------------------------------
  always @* begin
    case (ISSUE_OP)
      `CIT_OP_SHIFT_LEFT, `CIT_OP_SHIFT_RIGHT: begin
        shamt = ISSUE_B[5:0];
      end
      `CIT_OP_SHIFT_LEFT_IMM, `CIT_OP_SHIFT_RIGHT_IMM: begin
        shamt = {1'b0, ISSUE_B[4:0]};
      end
      default: begin
        shamt = 6'h01;
      end
    endcase
    // a register amount whose low six bits are 32 to 63 clears the operand
    shl_v = shamt[5] ? 32'h00000000 : (ISSUE_A << shamt[4:0]);
    shr_v = shamt[5] ? 32'h00000000 : (ISSUE_A >> shamt[4:0]);
    dec_v = ISSUE_A - 32'h00000001;
  end

  // ----------------------------------------------------------------
  // decode: cycle count and architectural effect of each operation
  // ----------------------------------------------------------------
  always @* begin
    n_cyc = `CIT_CYC_SINGLE;
    res_v = 32'h00000000;
    res_we_v = 1'b0;
    carry_v = CARRY;
    taken_v = 1'b0;
    target_v = 32'h00000000;
    case (ISSUE_OP)
      `CIT_OP_JUMP_DIRECT: begin
        n_cyc = `CIT_CYC_JUMP_DIRECT;
        taken_v = 1'b1;
        target_v = ISSUE_A;
      end
      `CIT_OP_JUMP_INDIRECT: begin
        n_cyc = `CIT_CYC_JUMP_INDIRECT;
        taken_v = 1'b1;
        target_v = ISSUE_A;
      end
      `CIT_OP_CALL_DIRECT: begin
        n_cyc = `CIT_CYC_JUMP_DIRECT;
        taken_v = 1'b1;
        target_v = ISSUE_A;
        res_v = ISSUE_B;
        res_we_v = 1'b1;
      end
      `CIT_OP_CALL_INDIRECT: begin
        n_cyc = `CIT_CYC_JUMP_INDIRECT;
        taken_v = 1'b1;
        target_v = ISSUE_A;
        res_v = ISSUE_B;
        res_we_v = 1'b1;
      end
      `CIT_OP_BRANCH_TRUE: begin
        taken_v = CARRY;
        target_v = ISSUE_A;
        n_cyc = CARRY ? `CIT_CYC_BRANCH_TAKEN : `CIT_CYC_BRANCH_UNTAKEN;
      end
      `CIT_OP_BRANCH_FALSE: begin
        taken_v = ~CARRY;
        target_v = ISSUE_A;
        n_cyc = CARRY ? `CIT_CYC_BRANCH_UNTAKEN : `CIT_CYC_BRANCH_TAKEN;
      end
      `CIT_OP_LOAD_MULTI_REGS, `CIT_OP_STORE_MULTI_REGS: begin
        n_cyc = ISSUE_REG_COUNT + `CIT_CYC_SINGLE;
      end
      `CIT_OP_LOOP_DECREMENT_BRANCH: begin
        // carry set while the decremented count stays above zero
        res_v = dec_v;
        res_we_v = 1'b1;
        carry_v = ~dec_v[31] && (dec_v != 32'h00000000);
        taken_v = carry_v;
        target_v = ISSUE_B;
        n_cyc = carry_v ? `CIT_CYC_BRANCH_TAKEN : `CIT_CYC_BRANCH_UNTAKEN;
      end
      `CIT_OP_SHIFT_LEFT, `CIT_OP_SHIFT_LEFT_IMM: begin
        res_v = shl_v;
        res_we_v = 1'b1;
      end
      `CIT_OP_SHIFT_RIGHT, `CIT_OP_SHIFT_RIGHT_IMM: begin
        res_v = shr_v;
        res_we_v = 1'b1;
      end
      `CIT_OP_SHIFT_LEFT_CARRY: begin
        res_v = shl_v;
        res_we_v = 1'b1;
        carry_v = ISSUE_A[31];
      end
      `CIT_OP_SHIFT_RIGHT_CARRY: begin
        res_v = shr_v;
        res_we_v = 1'b1;
        carry_v = ISSUE_A[0];
      end
      `CIT_OP_COPY_CARRY_TO_REG: begin
        res_v = {31'h00000000, CARRY};
        res_we_v = 1'b1;
      end
      `CIT_OP_COPY_INV_CARRY_TO_REG: begin
        res_v = {31'h00000000, ~CARRY};
        res_we_v = 1'b1;
      end
      `CIT_OP_TEST_NO_ZERO_BYTE: begin
        carry_v = &byte_nz;
      end
      `CIT_OP_MULTIPLY_OP: begin
        n_cyc = multiply_op_latency;
        res_v = multiply_op_product;
        res_we_v = 1'b1;
      end
      default: begin
        n_cyc = `CIT_CYC_SINGLE;
      end
    endcase
    if ((ISSUE_OP == `CIT_OP_LOAD_MULTI_REGS) || (ISSUE_OP == `CIT_OP_STORE_MULTI_REGS)) begin
      occ = {1'b0, ISSUE_REG_COUNT} + 6'h01;
    end else begin
      occ = {1'b0, n_cyc};
    end
  end

  // ----------------------------------------------------------------
  // sequencer: counts the occupancy, holds halt ops until the bus drains
  // ----------------------------------------------------------------
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    op_sel = op_q;
    case (st_q)
      ST_DRAIN: begin
        // a halt op acts only once the outstanding bus transaction has ended
        if (!BUS_PENDING) begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      ST_BUSY: begin
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          st_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          op_sel = ISSUE_OP;
          if (issue_halt && BUS_PENDING) begin
            st_d = ST_DRAIN;
          end else if (occ <= 6'h01) begin
            done_d = 1'b1;
          end else begin
            st_d = ST_BUSY;
            cnt_d = occ - 6'h01;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    ready_d = (st_d == ST_IDLE);
    halt_d = done_d && is_halt_op(op_sel);
  end

  // ----------------------------------------------------------------
  // sequencer and pulse registers
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_q <= ST_IDLE;
      cnt_q <= 6'h00;
      ISSUE_READY <= 1'b0;
      DONE <= 1'b0;
      HALT_REQ <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ISSUE_READY <= ready_d;
      DONE <= done_d;
      HALT_REQ <= halt_d;
    end
  end

  // ----------------------------------------------------------------
  // completion registers, loaded at the accept edge, held until the next
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      op_q <= 5'h00;
      DONE_OP <= 5'h00;
      CYCLES <= 5'h00;
      RESULT <= 32'h00000000;
      RESULT_WE <= 1'b0;
      CARRY <= 1'b0;
      BRANCH_TAKEN <= 1'b0;
      BRANCH_TARGET <= 32'h00000000;
    end else if (accept) begin
      op_q <= ISSUE_OP;
      DONE_OP <= ISSUE_OP;
      CYCLES <= n_cyc;
      RESULT <= res_v;
      RESULT_WE <= res_we_v;
      CARRY <= carry_v;
      BRANCH_TAKEN <= taken_v;
      BRANCH_TARGET <= target_v;
    end
  end

endmodule // cit_core_timing

// file: core/cit_defines.vh
// cit_defines.vh: operation codes and cycle counts of the execution timing core
// assumes: included by bare name from every design file that needs it
`ifndef CIT_DEFINES_VH
`define CIT_DEFINES_VH

// ----------------------------------------------------------------
// operation codes (5 bits)
// ----------------------------------------------------------------
`define CIT_OP_W 5
`define CIT_OP_JUMP_DIRECT 5'h00
`define CIT_OP_JUMP_INDIRECT 5'h01
`define CIT_OP_CALL_DIRECT 5'h02
`define CIT_OP_CALL_INDIRECT 5'h03
`define CIT_OP_BRANCH_TRUE 5'h04
`define CIT_OP_BRANCH_FALSE 5'h05
`define CIT_OP_LOAD_MULTI_REGS 5'h06
`define CIT_OP_STORE_MULTI_REGS 5'h07
`define CIT_OP_LOOP_DECREMENT_BRANCH 5'h08
`define CIT_OP_SHIFT_LEFT 5'h09
`define CIT_OP_SHIFT_RIGHT 5'h0a
`define CIT_OP_SHIFT_LEFT_IMM 5'h0b
`define CIT_OP_SHIFT_RIGHT_IMM 5'h0c
`define CIT_OP_SHIFT_LEFT_CARRY 5'h0d
`define CIT_OP_SHIFT_RIGHT_CARRY 5'h0e
`define CIT_OP_COPY_CARRY_TO_REG 5'h0f
`define CIT_OP_COPY_INV_CARRY_TO_REG 5'h10
`define CIT_OP_TEST_NO_ZERO_BYTE 5'h11
`define CIT_OP_MULTIPLY_OP 5'h12
`define CIT_OP_BREAKPOINT_OP 5'h13
`define CIT_OP_DOZE_OP 5'h14
`define CIT_OP_WAIT_OP 5'h15
`define CIT_OP_STOP_OP 5'h16

// ----------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------
`define CIT_CNT_W 5
`define CIT_CYC_SINGLE 5'h01
`define CIT_CYC_JUMP_DIRECT 5'h02
`define CIT_CYC_JUMP_INDIRECT 5'h03
`define CIT_CYC_BRANCH_UNTAKEN 5'h01
`define CIT_CYC_BRANCH_TAKEN 5'h02
`define CIT_CYC_MULTIPLY_OP_MIN 5'h03
`define CIT_CYC_MULTIPLY_OP_MAX 5'h12
`define CIT_CYC_MULTIPLY_OP_BASE 5'h02
`define CIT_REG_COUNT_W 5

`endif

// file: core/cit_multiply_op_latency.v
// cit_multiply_op_latency: 32-bit product and its result-magnitude dependent latency
// assumes: purely combinational, operands stable while sampled by the caller
`timescale 1ns/10ps
`include "cit_defines.vh"

module cit_multiply_op_latency (
  // operands
  input wire [31:0] op_a,
  input wire [31:0] op_b,
  // result
  output wire [31:0] product,
  output reg [4:0] latency
);

  reg [5:0] sig_bits;
  reg [5:0] half_bits;
  reg [4:0] lat_raw;
  integer i;

  assign product = op_a * op_b;

  // ----------------------------------------------------------------
  // significant bits of the result
  // ----------------------------------------------------------------
  always @* begin
    sig_bits = 6'h00;
    for (i = 0; i < 32; i = i + 1) begin
      if (product[i]) begin
        sig_bits = i[5:0] + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // two result bits per cycle on top of a fixed base, clamped 3..18
  // ----------------------------------------------------------------
  always @* begin
    half_bits = (sig_bits + 6'h01) >> 1;
    lat_raw = `CIT_CYC_MULTIPLY_OP_BASE + half_bits[4:0];
    if (lat_raw < `CIT_CYC_MULTIPLY_OP_MIN) begin
      latency = `CIT_CYC_MULTIPLY_OP_MIN;
    end else if (lat_raw > `CIT_CYC_MULTIPLY_OP_MAX) begin
      latency = `CIT_CYC_MULTIPLY_OP_MAX;
    end else begin
      latency = lat_raw;
    end
  end

endmodule // cit_multiply_op_latency

// file: test/cit_bus_model.sv
// system bus model: a started transaction stays outstanding for len cycles
// assumes: start is a one-cycle request on the core clock
`timescale 1ns/10ps
module cit_bus_model (
  // clock and request
  input wire clk,
  input wire start,
  input wire [3:0] len,
  // status
  output wire pending
);
  reg [3:0] left_q = 4'h0;
  always @(posedge clk) begin
    if (start) begin
      left_q <= len;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
  assign pending = left_q != 4'h0;
endmodule // cit_bus_model

// file: test/cit_core_timing_asserts.sv
// checker for cit_core_timing: cycle relations seen at its ports
// assumes: bound to every cit_core_timing instance, codes from cit_defines.vh
`timescale 1ns/10ps
`include "cit_defines.vh"
module cit_core_timing_asserts (
  input wire SYS_CLK,
  input wire RST_N,
  input wire ISSUE_VALID,
  input wire [4:0] ISSUE_OP,
  input wire [31:0] ISSUE_A,
  input wire [4:0] ISSUE_REG_COUNT,
  input wire ISSUE_READY,
  input wire BUS_PENDING,
  input wire DONE,
  input wire [4:0] DONE_OP,
  input wire [4:0] CYCLES,
  input wire [31:0] RESULT,
  input wire CARRY,
  input wire HALT_REQ
);
  wire acc = ISSUE_VALID && ISSUE_READY;
  wire [4:0] o = ISSUE_OP;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  chk_jump_direct: assert property (acc && o == `CIT_OP_JUMP_DIRECT |=> !DONE ##1 DONE)
    else $error("direct jump not 2 cycles");
  chk_jump_indirect: assert property (acc && o == `CIT_OP_JUMP_INDIRECT |=> !DONE[*2] ##1 DONE)
    else $error("indirect jump not 3 cycles");
  chk_branch_taken: assert property (acc && o == `CIT_OP_BRANCH_TRUE && CARRY |=> !DONE ##1 DONE)
    else $error("taken branch not 2 cycles");
  chk_branch_untaken: assert property (acc && o == `CIT_OP_BRANCH_FALSE && CARRY |=> DONE)
    else $error("untaken branch not 1 cycle");
  chk_multi_count: assert property (acc && (o == `CIT_OP_LOAD_MULTI_REGS ||
      o == `CIT_OP_STORE_MULTI_REGS) |=> CYCLES == $past(ISSUE_REG_COUNT) + 5'h01)
    else $error("multiple transfer count wrong");
  chk_loop_result: assert property (acc && o == `CIT_OP_LOOP_DECREMENT_BRANCH
      |=> RESULT == $past(ISSUE_A) - 32'h1) else $error("loop decrement wrong");
  chk_single_cycle: assert property (acc && o >= `CIT_OP_SHIFT_LEFT &&
      o <= `CIT_OP_TEST_NO_ZERO_BYTE |=> DONE && CYCLES == 5'h01) else $error("not 1 cycle");
  chk_carry_out: assert property (acc && o == `CIT_OP_SHIFT_LEFT_CARRY
      |=> CARRY == $past(ISSUE_A[31])) else $error("carry not bit shifted out");
  chk_multiply_op_range: assert property (DONE && DONE_OP == `CIT_OP_MULTIPLY_OP
      |-> CYCLES >= 5'h03 && CYCLES <= 5'h12) else $error("multiply latency out of range");
  chk_halt_drain: assert property (HALT_REQ |-> DONE && !$past(BUS_PENDING))
    else $error("halt acted with bus busy");
endmodule // cit_core_timing_asserts

bind cit_core_timing cit_core_timing_asserts u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .ISSUE_VALID(ISSUE_VALID), .ISSUE_OP(ISSUE_OP), .ISSUE_A(ISSUE_A),
  .ISSUE_REG_COUNT(ISSUE_REG_COUNT), .ISSUE_READY(ISSUE_READY), .BUS_PENDING(BUS_PENDING),
  .DONE(DONE), .DONE_OP(DONE_OP), .CYCLES(CYCLES), .RESULT(RESULT), .CARRY(CARRY),
  .HALT_REQ(HALT_REQ));

// file: test/cit_core_timing_test.sv
// testbench for cit_core_timing: measures cycle counts and results per operation
// assumes: bus model drives the pending line, checker bound to the design
`timescale 1ns/10ps
`include "cit_defines.vh"
module cit_core_timing_test;
  reg sys_clk, rst_n, valid, bstart;
  reg [4:0] op, cnt;
  reg [31:0] a, b;
  reg [3:0] blen;
  wire ready, pend, done, rwe, carry, btaken, halt;
  wire [4:0] done_op, cycles;
  wire [31:0] result, btarget;
  integer err_count, num_checks, cyc, i;
  cit_core_timing DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .ISSUE_VALID(valid), .ISSUE_OP(op),
    .ISSUE_A(a), .ISSUE_B(b), .ISSUE_REG_COUNT(cnt), .ISSUE_READY(ready), .BUS_PENDING(pend),
    .DONE(done), .DONE_OP(done_op), .CYCLES(cycles), .RESULT(result), .RESULT_WE(rwe),
    .CARRY(carry), .BRANCH_TAKEN(btaken), .BRANCH_TARGET(btarget), .HALT_REQ(halt));
  cit_bus_model u_bus (.clk(sys_clk), .start(bstart), .len(blen), .pending(pend));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // issue one op, count cycles from accept to the completion pulse
  task run(input [4:0] o, input [31:0] x, input [31:0] y, input [4:0] n, input integer ex);
    integer k;
    begin
      @(negedge sys_clk);
      op = o; a = x; b = y; cnt = n; valid = 1'b1;
      k = 0;
      while (ready !== 1'b1 && k < 40) begin
        @(negedge sys_clk);
        k = k + 1;
      end
      @(negedge sys_clk);
      valid = 1'b0;
      cyc = 1;
      while (done !== 1'b1 && cyc < 40) begin
        @(negedge sys_clk);
        cyc = cyc + 1;
      end
      chk("cycles", ex, cyc);
      chk("op", o, done_op);
      chk("halt", (o >= `CIT_OP_BREAKPOINT_OP) && (o <= `CIT_OP_STOP_OP), halt);
    end
  endtask
  task t_jump;
    begin
      run(`CIT_OP_JUMP_DIRECT, 32'h100, 0, 0, 2);
      chk("jtaken", 1, btaken);
      chk("jtgt", 32'h100, btarget);
      chk("jwe", 0, rwe);
      run(`CIT_OP_CALL_DIRECT, 32'h200, 32'h44, 0, 2);
      chk("ret", 32'h44, result);
      chk("cwe", 1, rwe);
      run(`CIT_OP_JUMP_INDIRECT, 32'h300, 0, 0, 3);
      run(`CIT_OP_CALL_INDIRECT, 32'h400, 0, 0, 3);
      $display("jump end");
    end
  endtask
  task t_loop;
    begin
      run(`CIT_OP_LOOP_DECREMENT_BRANCH, 2, 32'h40, 0, 2);
      chk("loop", 32'h1, {result[31:1], carry});
      chk("ltaken", 1, btaken);
      chk("ltgt", 32'h40, btarget);
      run(`CIT_OP_LOOP_DECREMENT_BRANCH, 1, 32'h40, 0, 1);
      chk("loop", 32'h0, {result[31:1], carry});
      chk("ltaken", 0, btaken);
      $display("loop end");
    end
  endtask
  task t_branch;
    begin
      run(`CIT_OP_TEST_NO_ZERO_BYTE, 32'h01010101, 0, 0, 1);
      chk("flag", 1, carry);
      chk("twe", 0, rwe);
      run(`CIT_OP_BRANCH_TRUE, 32'h80, 0, 0, 2);
      chk("btaken", 1, btaken);
      chk("btgt", 32'h80, btarget);
      run(`CIT_OP_BRANCH_FALSE, 32'h80, 0, 0, 1);
      run(`CIT_OP_TEST_NO_ZERO_BYTE, 32'h01000101, 0, 0, 1);
      chk("flag", 0, carry);
      run(`CIT_OP_BRANCH_TRUE, 32'h80, 0, 0, 1);
      chk("btaken", 0, btaken);
      run(`CIT_OP_BRANCH_FALSE, 32'h80, 0, 0, 2);
      $display("branch end");
    end
  endtask
  task t_multi;
    begin
      run(`CIT_OP_LOAD_MULTI_REGS, 0, 0, 0, 1);
      run(`CIT_OP_LOAD_MULTI_REGS, 0, 0, 30, 31);
      run(`CIT_OP_STORE_MULTI_REGS, 0, 0, 5, 6);
      run(`CIT_OP_STORE_MULTI_REGS, 0, 0, 31, 32);
      $display("multi end");
    end
  endtask
  task t_shift;
    begin
      run(`CIT_OP_SHIFT_LEFT, 1, 4, 0, 1);
      chk("shl", 32'h10, result);
      chk("swe", 1, rwe);
      run(`CIT_OP_SHIFT_RIGHT, 32'h100, 40, 0, 1);
      chk("shr", 0, result);
      run(`CIT_OP_SHIFT_LEFT_IMM, 1, 31, 0, 1);
      chk("shli", 32'h80000000, result);
      run(`CIT_OP_SHIFT_RIGHT_IMM, 32'h80000000, 31, 0, 1);
      chk("shri", 1, result);
      $display("shift end");
    end
  endtask
  task t_carry;
    begin
      run(`CIT_OP_SHIFT_LEFT_CARRY, 32'h80000001, 0, 0, 1);
      chk("shlc", 32'h5, {result[30:0], carry});
      run(`CIT_OP_COPY_CARRY_TO_REG, 0, 0, 0, 1);
      chk("cc", 1, result);
      run(`CIT_OP_SHIFT_RIGHT_CARRY, 2, 0, 0, 1);
      chk("shrc", 32'h2, {result[30:0], carry});
      run(`CIT_OP_COPY_INV_CARRY_TO_REG, 0, 0, 0, 1);
      chk("ci", 1, result);
      $display("carry end");
    end
  endtask
  task t_multiply_op;
    begin
      run(`CIT_OP_MULTIPLY_OP, 3, 5, 0, 4);
      chk("prod", 32'hf, result);
      run(`CIT_OP_MULTIPLY_OP, 0, 0, 0, 3);
      run(`CIT_OP_MULTIPLY_OP, 32'h80000000, 1, 0, 18);
      $display("multiply_op end");
    end
  endtask
  task t_halt;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        run(`CIT_OP_BREAKPOINT_OP + i, 0, 0, 0, 1);
        chk("halt", 1, halt);
      end
      @(negedge sys_clk);
      bstart = 1'b1;
      @(negedge sys_clk);
      bstart = 1'b0;
      // bus busy at accept: completion waits for the transaction to end
      run(`CIT_OP_WAIT_OP, 0, 0, 0, 6);
      chk("halt", 1, halt);
      chk("hcyc", 1, cycles);
      $display("halt end");
    end
  endtask
  // reset in mid-operation: outputs clear and a new op runs normally
  task t_reset;
    begin
      @(negedge sys_clk);
      op = `CIT_OP_LOAD_MULTI_REGS; cnt = 5'h10; valid = 1'b1;
      repeat (3) @(negedge sys_clk);
      valid = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("rst", 0, {ready, done, cycles, halt});
      rst_n = 1'b1;
      run(`CIT_OP_JUMP_DIRECT, 32'h600, 0, 0, 2);
      $display("reset end");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    err_count = 0; num_checks = 0; rst_n = 1'b0; valid = 1'b0; bstart = 1'b0;
    blen = 4'h6; op = 5'h00; cnt = 5'h00; a = 32'h0; b = 32'h0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    t_jump;
    t_loop;
    t_branch;
    t_multi;
    t_shift;
    t_carry;
    t_multiply_op;
    t_halt;
    t_reset;
    stop_test;
  end
  // whole run needs well under 1000 cycles
  initial begin
    #40000;
    err_count = err_count + 1;
    stop_test;
  end
endmodule // cit_core_timing_test
